// *** asq_pkg.sv ***
// Shared constants for the converter sequencer control block
package asq_pkg;
    localparam logic [1:0] ADDR_STATUS_CONTROL = 2'h0;
    localparam logic [1:0] ADDR_RESULT         = 2'h1;
    localparam logic [1:0] ADDR_CLOCK_CONFIG   = 2'h2;
    localparam int         DONE_BIT            = 7;
    localparam int         IRQ_EN_BIT          = 6;
    localparam int         CONT_BIT            = 5;
    localparam int         CLK_SRC_BIT         = 4;
    localparam logic [4:0] CHAN_RESET          = 5'h1F;
    localparam logic [4:0] CHAN_POWER_OFF      = 5'h1F;
    localparam logic [4:0] CHAN_LAST_PORT_B    = 5'h07;
    localparam logic [4:0] CHAN_LAST_PORT_D    = 5'h0E;
    localparam logic [4:0] CHAN_RESERVED       = 5'h1B;
    localparam logic [4:0] CHAN_REF_HIGH       = 5'h1D;
    localparam logic [4:0] CHAN_REF_LOW        = 5'h1E;
    localparam logic [2:0] PRESCALE_RESET      = 3'h0;
    localparam logic       CLK_SRC_RESET       = 1'b0;
    localparam int         SAR_BITS            = 8;
    localparam int         CONV_CYCLES         = 16;
    localparam logic [4:0] CONV_LAST_TICK      = 5'(CONV_CYCLES - 1);
    localparam logic [3:0] DIV16_TERMINAL      = 4'hF;
endpackage : asq_pkg

// *** asq_clock_divider.sv ***
// Converter clock source select and prescaler tick generator
module asq_clock_divider
    import asq_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       arst_n,
    input  wire logic       clkEn,
    input  wire logic       extClkSync,
    input  wire logic       useBusClock,
    input  wire logic [2:0] prescale,
    input  wire logic       restart,
    output logic            convTick
);
    logic       extPrev_reg;
    logic       extPrev_next;
    logic [3:0] div_reg;
    logic [3:0] div_next;
    logic       tick_reg;
    logic       tick_next;
    logic       srcEdge;
    logic [3:0] terminal;

    always_comb begin
        srcEdge      = useBusClock ? 1'b1 : (extClkSync & ~extPrev_reg);
        extPrev_next = extClkSync;
        // Top bit overrides the low bits, so this is a priority choice
        if (prescale[2]) begin
            terminal = DIV16_TERMINAL;
        end else if (prescale[1:0] == 2'h0) begin
            terminal = 4'h0;
        end else if (prescale[1:0] == 2'h1) begin
            terminal = 4'h1;
        end else if (prescale[1:0] == 2'h2) begin
            terminal = 4'h3;
        end else begin
            terminal = 4'h7;
        end
        div_next  = div_reg;
        tick_next = 1'b0;
        if (restart) begin
            div_next = 4'h0;
        end else if (srcEdge) begin
            if (div_reg >= terminal) begin
                div_next  = 4'h0;
                tick_next = 1'b1;
            end else begin
                div_next = div_reg + 4'h1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            extPrev_reg <= 1'b0;
            div_reg     <= 4'h0;
            tick_reg    <= 1'b0;
        end else if (clkEn) begin
            extPrev_reg <= extPrev_next;
            div_reg     <= div_next;
            tick_reg    <= tick_next;
        end
    end

    assign convTick = tick_reg;
endmodule : asq_clock_divider

// *** asq_sequencer.sv ***
// Converter sequencer: registers, conversion control, power and mode handling
module asq_sequencer
    import asq_pkg::*;
(
    input  wire logic                ref_clk,
    input  wire logic                arst_n,
    input  wire logic                clkEn,
    input  wire logic [1:0]          regAddr,
    input  wire logic [7:0]          regWrData,
    input  wire logic                regWrite,
    input  wire logic                regRead,
    output logic [7:0]               regRdData,
    input  wire logic                external_ref_clock,
    input  wire logic                stopMode,
    input  wire logic                compareHigh,
    output logic [4:0]               input_channel_select,
    output logic                     selectedInputValid,
    output logic                     highRefSelect,
    output logic                     lowRefSelect,
    output logic                     analogPowerOn,
    output logic                     sampleHold,
    output logic [asq_pkg::SAR_BITS-1:0] sarTrial,
    output logic                     convIrq
);
    typedef enum logic [2:0] {
        IDLE    = 3'b001,
        CONVERT = 3'b010,
        HALTED  = 3'b100
    } asq_state_t;

    asq_state_t          state_reg, state_next;
    logic                conv_done_flag_reg, conv_done_flag_next;
    logic                conv_irq_enable_reg, conv_irq_enable_next;
    logic                continuous_conv_reg, continuous_conv_next;
    logic [4:0]          chan_reg, chan_next;
    logic [2:0]          conv_clock_prescale_reg, conv_clock_prescale_next;
    logic                conv_clock_source_reg, conv_clock_source_next;
    logic [7:0]          result_reg, result_next;
    logic [7:0]          sar_reg, sar_next;
    logic [4:0]          tick_reg, tick_next;
    logic [7:0]          rd_reg, rd_next;
    logic                irq_reg, irq_next;
    logic                extMeta_reg, extSync_reg;
    logic                stopMeta_reg, stopSync_reg;
    logic                convTick;
    logic                ctrlWrite, resultRead, restartDiv, convEnd;
    logic [2:0]          bitIdx;

    // Pins cross in on two flops each
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            extMeta_reg  <= 1'b0;
            extSync_reg  <= 1'b0;
            stopMeta_reg <= 1'b0;
            stopSync_reg <= 1'b0;
        end else if (clkEn) begin
            extMeta_reg  <= external_ref_clock;
            extSync_reg  <= extMeta_reg;
            stopMeta_reg <= stopMode;
            stopSync_reg <= stopMeta_reg;
        end
    end

    asq_clock_divider u_divider (
        .ref_clk     (ref_clk),
        .arst_n      (arst_n),
        .clkEn       (clkEn),
        .extClkSync  (extSync_reg),
        .useBusClock (conv_clock_source_reg),
        .prescale    (conv_clock_prescale_reg),
        .restart     (restartDiv),
        .convTick    (convTick)
    );

    always_comb begin
        ctrlWrite  = regWrite && regAddr == ADDR_STATUS_CONTROL;
        resultRead = regRead && regAddr == ADDR_RESULT;
        bitIdx     = 3'(7 - tick_reg[4:1]);
        convEnd    = state_reg == CONVERT && convTick && tick_reg == CONV_LAST_TICK;
        restartDiv = ctrlWrite || state_reg != CONVERT;

        state_next               = state_reg;
        conv_done_flag_next      = conv_done_flag_reg;
        conv_irq_enable_next     = conv_irq_enable_reg;
        continuous_conv_next     = continuous_conv_reg;
        chan_next                = chan_reg;
        conv_clock_prescale_next = conv_clock_prescale_reg;
        conv_clock_source_next   = conv_clock_source_reg;
        result_next              = result_reg;
        sar_next                 = sar_reg;
        tick_next                = tick_reg;
        irq_next                 = irq_reg;
        rd_next                  = 8'h00;

        // Sixteen ticks: even tick sets trial bit, odd tick keeps or drops it
        if (state_reg == CONVERT && convTick) begin
            tick_next = tick_reg + 5'h01;
            if (!tick_reg[0]) begin
                sar_next[bitIdx] = 1'b1;
            // Comparator sits on this clock; a synchroniser would lag undivided ticks
            end else if (!compareHigh) begin
                sar_next[bitIdx] = 1'b0;
            end
        end

        // Result-read clears go first so a completing conversion wins over a read in the same cycle; a control write still beats it
        if (resultRead && !conv_irq_enable_reg) begin
            conv_done_flag_next = 1'b0;
        end
        if (resultRead) begin
            irq_next = 1'b0;
        end
        if (regWrite && regAddr == ADDR_CLOCK_CONFIG) begin
            conv_clock_prescale_next = regWrData[2:0];
            conv_clock_source_next   = regWrData[CLK_SRC_BIT];
        end
        if (ctrlWrite) begin
            conv_irq_enable_next = regWrData[IRQ_EN_BIT];
            continuous_conv_next = regWrData[CONT_BIT];
            chan_next            = regWrData[4:0];
            irq_next             = 1'b0;
            // Flag writable only under interrupt mode, else a write clears it
            conv_done_flag_next  = regWrData[IRQ_EN_BIT] ? regWrData[DONE_BIT] : 1'b0;
            tick_next            = 5'h00;
            sar_next             = 8'h00;
            state_next = regWrData[4:0] == CHAN_POWER_OFF ? IDLE : CONVERT;
        end else if (convEnd) begin
            result_next = sar_next;
            if (conv_irq_enable_reg) begin
                irq_next = 1'b1;
            end else begin
                conv_done_flag_next = 1'b1;
            end
            tick_next  = 5'h00;
            sar_next   = 8'h00;
            state_next = continuous_conv_reg ? CONVERT : IDLE;
        end

        // Stop wins: abort, then resume the mode on exit
        if (stopSync_reg) begin
            if (state_reg == CONVERT || state_next == CONVERT) begin
                state_next = HALTED;
            end
            tick_next = 5'h00;
            sar_next  = 8'h00;
        end else if (state_reg == HALTED && !ctrlWrite) begin
            state_next = CONVERT;
        end

        if (regRead) begin
            unique case (regAddr)
                ADDR_STATUS_CONTROL: rd_next = {conv_done_flag_reg, conv_irq_enable_reg,
                                                continuous_conv_reg, chan_reg};
                ADDR_RESULT:         rd_next = result_reg;
                ADDR_CLOCK_CONFIG:   rd_next = {3'h0, conv_clock_source_reg, 1'b0,
                                                conv_clock_prescale_reg};
                default:             rd_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg               <= IDLE;
            conv_done_flag_reg      <= 1'b0;
            conv_irq_enable_reg     <= 1'b0;
            continuous_conv_reg     <= 1'b0;
            chan_reg                <= CHAN_RESET;
            conv_clock_prescale_reg <= PRESCALE_RESET;
            conv_clock_source_reg   <= CLK_SRC_RESET;
            result_reg              <= 8'h00;
            sar_reg                 <= 8'h00;
            tick_reg                <= 5'h00;
            rd_reg                  <= 8'h00;
            irq_reg                 <= 1'b0;
        end else if (clkEn) begin
            state_reg               <= state_next;
            conv_done_flag_reg      <= conv_done_flag_next;
            conv_irq_enable_reg     <= conv_irq_enable_next;
            continuous_conv_reg     <= continuous_conv_next;
            chan_reg                <= chan_next;
            conv_clock_prescale_reg <= conv_clock_prescale_next;
            conv_clock_source_reg   <= conv_clock_source_next;
            result_reg              <= result_next;
            sar_reg                 <= sar_next;
            tick_reg                <= tick_next;
            rd_reg                  <= rd_next;
            irq_reg                 <= irq_next;
        end
    end

    // Decoded analog steering, registered so outputs come from flops
    logic [4:0] chanOut_reg;
    logic       validOut_reg, highOut_reg, lowOut_reg, powerOut_reg, holdOut_reg;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            chanOut_reg  <= CHAN_RESET;
            validOut_reg <= 1'b0;
            highOut_reg  <= 1'b0;
            lowOut_reg   <= 1'b0;
            powerOut_reg <= 1'b0;
            holdOut_reg  <= 1'b0;
        end else if (clkEn) begin
            chanOut_reg  <= chan_next;
            validOut_reg <= chan_next <= CHAN_LAST_PORT_D;
            highOut_reg  <= chan_next == CHAN_REF_HIGH;
            lowOut_reg   <= chan_next == CHAN_REF_LOW;
            powerOut_reg <= chan_next != CHAN_POWER_OFF && !stopSync_reg;
            holdOut_reg  <= state_next == CONVERT;
        end
    end

    assign input_channel_select = chanOut_reg;
    assign selectedInputValid   = validOut_reg;
    assign highRefSelect        = highOut_reg;
    assign lowRefSelect         = lowOut_reg;
    assign analogPowerOn        = powerOut_reg;
    assign sampleHold           = holdOut_reg;
    assign sarTrial             = sar_reg;
    assign regRdData            = rd_reg;
    assign convIrq              = irq_reg;
endmodule : asq_sequencer

// *** asq_sequencer_asserts.sv ***
// Port-level assertions for the converter sequencer
module asq_sequencer_asserts
    import asq_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       arst_n,
    input wire logic [1:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic       stopMode,
    input wire logic [4:0] input_channel_select,
    input wire logic       selectedInputValid,
    input wire logic       highRefSelect,
    input wire logic       lowRefSelect,
    input wire logic       analogPowerOn,
    input wire logic       sampleHold,
    input wire logic       convIrq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    logic clearAccess;
    // Either access drops a pending request
    assign clearAccess = (regRead && regAddr == ADDR_RESULT)
                       || (regWrite && regAddr == ADDR_STATUS_CONTROL);
    sequence start_write;
        regWrite && regAddr == ADDR_STATUS_CONTROL && regWrData[4:0] != CHAN_POWER_OFF;
    endsequence
    sequence quiet_stop;
        (!stopMode)[*4];
    endsequence
    AST_RESET_CHAN: assert property ($rose(arst_n) |-> input_channel_select == CHAN_RESET)
        else $error("channel not off after reset");
    AST_POWER_OFF: assert property ((input_channel_select == CHAN_POWER_OFF)[*2] |-> !analogPowerOn)
        else $error("powered with off code");
    // One cycle of slack; the decode registers from chan_next in the same cycle as the code
    AST_REF_SEL: assert property ($stable(input_channel_select) |->
        highRefSelect == (input_channel_select == CHAN_REF_HIGH)
        && lowRefSelect == (input_channel_select == CHAN_REF_LOW))
        else $error("reference select wrong");
    AST_VALID_RANGE: assert property ($stable(input_channel_select) |->
        selectedInputValid == (input_channel_select <= CHAN_LAST_PORT_D))
        else $error("input valid wrong");
    AST_IRQ_CLEAR: assert property (convIrq && !sampleHold && clearAccess |=> !convIrq)
        else $error("request not dropped");
    AST_IRQ_HOLD: assert property (convIrq && !clearAccess |=> convIrq)
        else $error("request dropped early");
    AST_STOP_ABORT: assert property (stopMode[*4] |-> !sampleHold && !analogPowerOn)
        else $error("active in stop");
    AST_CONV_START: assert property (quiet_stop ##0 start_write |-> ##[1:2] sampleHold)
        else $error("conversion not started");
endmodule : asq_sequencer_asserts

bind asq_sequencer asq_sequencer_asserts i_chk (.ref_clk(ref_clk), .arst_n(arst_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .stopMode(stopMode), .input_channel_select(input_channel_select),
    .selectedInputValid(selectedInputValid), .highRefSelect(highRefSelect),
    .lowRefSelect(lowRefSelect), .analogPowerOn(analogPowerOn), .sampleHold(sampleHold),
    .convIrq(convIrq));

// *** asq_analog_model.sv ***
// Behavioural multiplexer and comparator beside the sequencer
module asq_analog_model (
    input wire logic       ref_clk,
    input wire logic       slow,
    input wire logic [7:0] levels [32],
    input wire logic [4:0] input_channel_select,
    input wire logic       selectedInputValid,
    input wire logic       highRefSelect,
    input wire logic       lowRefSelect,
    input wire logic       analogPowerOn,
    input wire logic [7:0] sarTrial,
    output logic           compareHigh
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] level;
    logic       fresh;
    logic       late;
    logic       junk = 1'b0;
    logic       live;
    always_comb begin
        level = levels[input_channel_select];
        if (highRefSelect) level = 8'hFF;
        if (lowRefSelect) level = 8'h00;
        fresh = level >= sarTrial;
        live = analogPowerOn && (selectedInputValid || highRefSelect || lowRefSelect);
    end
    always @(posedge ref_clk) begin
        late <= fresh;
        junk <= ~junk;
    end
    // Unrouted or unpowered input gives no stable answer
    assign compareHigh = live ? (slow ? late : fresh) : junk;
endmodule : asq_analog_model

// *** asq_sequencer_tb.sv ***
// Self-checking bench for the converter sequencer
module asq_sequencer_tb
    import asq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic       ref_clk = 0, arst_n = 0, regWrite = 0, regRead = 0, stopMode = 0;
    logic       slow = 0, external_ref_clock = 0, rdPend = 0;
    logic       compareHigh, analogPowerOn, sampleHold, convIrq;
    logic [1:0] regAddr = 0;
    logic [7:0] regWrData = 0, regRdData, sarTrial;
    logic [7:0] lvl [32];
    logic [7:0] expQ [$];
    logic [7:0] chans [4] = '{8'h08, 8'h0E, 8'h1D, 8'h1E};
    int         num_errors = 0, checks_done = 0, n, d;
    integer     seed = 32'hB7AD3F3C;

    always #5 ref_clk = ~ref_clk;
    always #37 external_ref_clock = ~external_ref_clock;

    asq_sequencer i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .clkEn(1'b1), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .external_ref_clock(external_ref_clock), .stopMode(stopMode),
        .compareHigh(compareHigh), .input_channel_select(), .selectedInputValid(),
        .highRefSelect(), .lowRefSelect(), .analogPowerOn(analogPowerOn),
        .sampleHold(sampleHold), .sarTrial(sarTrial), .convIrq(convIrq));
    asq_analog_model i_ana (.ref_clk(ref_clk), .slow(slow), .levels(lvl),
        .input_channel_select(i_dut.input_channel_select),
        .selectedInputValid(i_dut.selectedInputValid), .highRefSelect(i_dut.highRefSelect),
        .lowRefSelect(i_dut.lowRefSelect), .analogPowerOn(analogPowerOn),
        .sarTrial(sarTrial), .compareHigh(compareHigh));

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWrData <= v;
        @(posedge ref_clk);
        regWrite <= 1'b0;
    endtask : wr

    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        regRead <= 1'b1;
        regAddr <= a;
        expQ.push_back(e);
        @(posedge ref_clk);
        regRead <= 1'b0;
    endtask : rd

    // Read data stand only in the cycle after the strobe
    always @(posedge ref_clk) begin
        if (rdPend) begin
            chk("regRdData", expQ[0], regRdData);
            expQ.delete(0);
        end
        rdPend <= regRead;
    end

    task automatic wait_idle;
        n = 1;
        @(posedge ref_clk);
        while (sampleHold !== 1'b0 && n < 3000) begin
            @(posedge ref_clk);
            n++;
        end
    endtask : wait_idle

    task automatic wait_irq;
        for (int i = 0; i < 3000 && convIrq !== 1'b1; i++) @(posedge ref_clk);
    endtask : wait_irq

    function automatic logic [7:0] ref_of(input logic [4:0] c);
        return c == 5'h1D ? 8'hFF : c == 5'h1E ? 8'h00 : lvl[c];
    endfunction : ref_of

    task automatic convert(input logic [7:0] ctl, input int lo, input int hi);
        wr(ADDR_STATUS_CONTROL, ctl);
        wait_idle();
        chk("convCycles", 8'h01, {7'h00, n >= lo && n <= hi});
        rd(ADDR_STATUS_CONTROL, 8'h80 | ctl);
        rd(ADDR_RESULT, ref_of(ctl[4:0]));
        rd(ADDR_STATUS_CONTROL, ctl);
    endtask : convert

    task automatic test_done;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (40000) @(posedge ref_clk);
        num_errors++;
        test_done();
    end

    initial begin
        for (int i = 0; i < 32; i++) lvl[i] = 8'($random(seed));
        repeat (5) @(posedge ref_clk);
        arst_n <= 1'b1;
        rd(ADDR_STATUS_CONTROL, 8'h1F);
        rd(ADDR_CLOCK_CONFIG, 8'h00);
        wr(ADDR_STATUS_CONTROL, 8'h04);
        wait_idle();
        convert(8'h04, 112, 136);
        for (int c = 0; c < 8; c++) begin
            d = c[2] ? 16 : 1 << c[1:0];
            slow <= c > 2;
            wr(ADDR_CLOCK_CONFIG, 8'h10 | 8'(c));
            rd(ADDR_CLOCK_CONFIG, 8'h10 | 8'(c));
            convert(8'(c), 16 * d, 17 * d + 6);
        end
        slow <= 1'b0;
        wr(ADDR_CLOCK_CONFIG, 8'h12);
        foreach (chans[i]) convert(chans[i], 64, 74);
        repeat (100) @(posedge ref_clk);
        chk("sampleHold", 8'h00, {7'h00, sampleHold});
        wr(2'h3, 8'hFF);
        wr(ADDR_RESULT, 8'h5A);
        rd(2'h3, 8'h00);
        rd(ADDR_RESULT, 8'h00);
        wr(ADDR_STATUS_CONTROL, 8'h01);
        repeat (20) @(posedge ref_clk);
        stopMode <= 1'b1;
        repeat (6) @(posedge ref_clk);
        chk("stopIdle", 8'h00, {6'h00, sampleHold, analogPowerOn});
        stopMode <= 1'b0;
        repeat (4) @(posedge ref_clk);
        wait_idle();
        rd(ADDR_RESULT, lvl[1]);
        wr(ADDR_STATUS_CONTROL, 8'h03);
        repeat (30) @(posedge ref_clk);
        convert(8'h05, 64, 74);
        wr(ADDR_STATUS_CONTROL, 8'h46);
        wait_irq();
        chk("convIrq", 8'h01, {7'h00, convIrq});
        rd(ADDR_STATUS_CONTROL, 8'h46);
        rd(ADDR_RESULT, lvl[6]);
        @(posedge ref_clk);
        chk("convIrq", 8'h00, {7'h00, convIrq});
        wr(ADDR_STATUS_CONTROL, 8'hC6);
        rd(ADDR_STATUS_CONTROL, 8'hC6);
        wait_irq();
        wr(ADDR_STATUS_CONTROL, 8'h46);
        @(posedge ref_clk);
        chk("convIrq", 8'h00, {7'h00, convIrq});
        wr(ADDR_STATUS_CONTROL, 8'h27);
        repeat (100) @(posedge ref_clk);
        lvl[7] <= ~lvl[7];
        repeat (220) @(posedge ref_clk);
        rd(ADDR_STATUS_CONTROL, 8'hA7);
        rd(ADDR_RESULT, lvl[7]);
        wr(ADDR_STATUS_CONTROL, 8'h1F);
        repeat (4) @(posedge ref_clk);
        chk("powerOff", 8'h00, {6'h00, sampleHold, analogPowerOn});
        test_done();
    end
endmodule : asq_sequencer_tb
